/* File: verilog/splmc_pkg.sv */
// constants shared by the loop, mirror and link control files
package splmc_pkg;
	localparam int NPORT = 8;
	localparam int PW = 3;
	// clock and timing
	localparam longint CLK_HZ = 100000000;
	localparam longint PROBE_PERIOD_S = 2;
	localparam longint SECS_PER_MIN = 60;
	localparam longint PROBE_PERIOD_CYC = PROBE_PERIOD_S * CLK_HZ;
	localparam int PERIODS_PER_MIN = int'(SECS_PER_MIN / PROBE_PERIOD_S);
	// register offsets
	localparam logic [7:0] OFS_LD_CTRL = 8'h00;
	localparam logic [7:0] OFS_LD_MAC_LO = 8'h04;
	localparam logic [7:0] OFS_LD_MAC_HI = 8'h08;
	localparam logic [7:0] OFS_LD_PORT_EN = 8'h0C;
	localparam logic [7:0] OFS_LD_RECOV_EN = 8'h10;
	localparam logic [7:0] OFS_LD_RECOV_TIME = 8'h14;
	localparam logic [7:0] OFS_LD_STATUS = 8'h18;
	localparam logic [7:0] OFS_LD_MANUAL = 8'h1C;
	localparam logic [7:0] OFS_MIR_CTRL = 8'h20;
	localparam logic [7:0] OFS_TRUNK = 8'h24;
	localparam logic [7:0] OFS_AN_EN = 8'h28;
	localparam logic [7:0] OFS_FC_EN = 8'h2C;
	localparam logic [7:0] OFS_SPEED = 8'h30;
	localparam logic [7:0] OFS_FULL = 8'h34;
	localparam logic [7:0] OFS_LINK_STATUS = 8'h38;
	localparam logic [7:0] OFS_LINK_SPEED = 8'h3C;
	// mirror control field positions
	localparam int MIR_EN_BIT = 0;
	localparam int MIR_ING_BIT = 1;
	localparam int MIR_EG_BIT = 2;
	localparam int MIR_SRC_LSB = 4;
	localparam int MIR_SRC_VLD_BIT = 7;
	localparam int MIR_DST_LSB = 8;
	// reset values and recovery time range
	localparam logic RST_LD_GLOBAL = 1'b1;
	localparam logic [7:0] RST_LD_PORT_EN = 8'h00;
	localparam logic [7:0] RST_RECOV_EN = 8'hFF;
	localparam logic [5:0] RST_RECOV_TIME = 6'h01;
	localparam logic [5:0] RECOV_MIN = 6'h01;
	localparam logic [5:0] RECOV_MAX = 6'h3C;
	localparam logic [7:0] RST_AN_EN = 8'hFF;
	localparam logic [7:0] RST_FC_EN = 8'h00;
	localparam logic [15:0] RST_SPEED = 16'hFFFF;
	localparam logic [7:0] RST_FULL = 8'hFF;
	// speed codes
	localparam logic [1:0] SPD_10 = 2'h0;
	localparam logic [1:0] SPD_100 = 2'h1;
	localparam logic [1:0] SPD_1000 = 2'h2;
	localparam logic [1:0] SPD_AUTO = 2'h3;
endpackage

/* File: verilog/splmc_loop_port.sv */
// per-port loop detection: probe pacing, blocking and timed recovery
`timescale 1ns/1ns
`default_nettype none
module splmc_loop_port (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick_probe,
	input wire logic tick_min,
	input wire logic probe_active,
	input wire logic recov_en,
	input wire logic [5:0] recov_time,
	input wire logic probe_rx,
	input wire logic manual_clr,
	output logic blocked,
	output logic manual_done,
	output logic probe_tx
);
	logic [5:0] min_cnt_reg;
	logic blocked_reg;
	logic done_reg;
	logic probe_tx_reg;
	wire block_set = probe_active & probe_rx;
	wire timed_out = blocked_reg & recov_en & tick_min & ((min_cnt_reg + 6'h01) >= recov_time);
	wire release_now = manual_clr | timed_out;

	assign blocked = blocked_reg;
	assign manual_done = done_reg;
	assign probe_tx = probe_tx_reg;

	// a fresh looped probe wins over a release in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			blocked_reg <= 1'b0;
		end else if (block_set) begin
			blocked_reg <= 1'b1; // [R1]
		end else if (release_now) begin
			blocked_reg <= 1'b0; // [R4]
		end
	end

	// minute counter restarts on blocking and clears on release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			min_cnt_reg <= 6'h00;
		end else if (block_set || release_now || !blocked_reg) begin
			min_cnt_reg <= 6'h00; // [R20]
		end else if (tick_min && recov_en) begin
			min_cnt_reg <= min_cnt_reg + 6'h01; // [R5] [R20]
		end
	end

	// manual recovery flag, cleared by the next block
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_reg <= 1'b0;
		end else if (block_set) begin
			done_reg <= 1'b0;
		end else if (manual_clr && blocked_reg) begin
			done_reg <= 1'b1; // [R7]
		end
	end

	// probing resumes by itself once the port is unblocked
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			probe_tx_reg <= 1'b0;
		end else begin
			probe_tx_reg <= tick_probe & probe_active & ~blocked_reg; // [R2] [R3] [R6]
		end
	end

	no_probe_blocked_a: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
		blocked_reg |=> !probe_tx_reg) else $error("probe sent on blocked port");
	block_on_loop_a: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
		block_set |=> blocked_reg) else $error("looped probe did not block");
	stay_blocked_a: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
		(blocked_reg && !recov_en && !manual_clr) |=> blocked_reg) else $error("port left block");
endmodule
`default_nettype wire

/* File: verilog/splmc_link_port.sv */
// per-port link resolution, crossover and flow control
`timescale 1ns/1ns
`default_nettype none
module splmc_link_port (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic an_en,
	input wire logic [1:0] cfg_speed,
	input wire logic cfg_full,
	input wire logic fc_en,
	input wire logic signal_det,
	input wire logic [1:0] line_speed,
	input wire logic partner_an,
	input wire logic [1:0] partner_speed,
	input wire logic partner_full,
	input wire logic cable_crossed,
	input wire logic rx_buf_full,
	input wire logic rx_carrier,
	output logic link_up,
	output logic [1:0] speed,
	output logic full,
	output logic mdix_swap,
	output logic pause_tx,
	output logic jam_tx
);
	logic up_reg;
	logic [1:0] speed_reg;
	logic full_reg;
	logic swap_reg;
	logic pause_reg;
	logic jam_reg;
	logic buf_full_d_reg;
	wire negotiated = an_en & partner_an;
	wire is_auto = (cfg_speed == splmc_pkg::SPD_AUTO);
	// negotiated links take the preset, or the partner's offer when preset is auto
	wire [1:0] nego_speed = is_auto ? partner_speed : cfg_speed; // [R17]
	wire nego_full = is_auto ? partner_full : cfg_full; // [R17]
	// without negotiation the line signal gives speed, always half duplex
	wire [1:0] speed_next = negotiated ? nego_speed : line_speed; // [R16]
	wire full_next = negotiated & nego_full; // [R16]
	wire buf_rise = rx_buf_full & ~buf_full_d_reg;

	assign link_up = up_reg;
	assign speed = speed_reg;
	assign full = full_reg;
	assign mdix_swap = swap_reg;
	assign pause_tx = pause_reg;
	assign jam_tx = jam_reg;

	// link state follows the line signal
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			up_reg <= 1'b0;
			speed_reg <= splmc_pkg::SPD_10;
			full_reg <= 1'b0;
			swap_reg <= 1'b0;
		end else begin
			up_reg <= signal_det;
			speed_reg <= speed_next;
			full_reg <= full_next;
			swap_reg <= is_auto & cable_crossed; // [R19]
		end
	end

	// one pause frame per buffer fill; jam held while the station still sends
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			buf_full_d_reg <= 1'b0;
			pause_reg <= 1'b0;
			jam_reg <= 1'b0;
		end else begin
			buf_full_d_reg <= rx_buf_full;
			pause_reg <= buf_rise & fc_en & up_reg & full_reg; // [R14]
			jam_reg <= rx_buf_full & rx_carrier & fc_en & up_reg & ~full_reg; // [R15]
		end
	end

	half_no_pause_a: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
		pause_reg |-> $past(full_reg)) else $error("pause in half duplex");
	swap_only_auto_a: assert property (@(posedge clk) disable iff (!rst_n) // [R19]
		swap_reg |-> $past(is_auto)) else $error("crossover swap outside auto");
endmodule
`default_nettype wire

/* File: verilog/splmc_ctrl.sv */
// top of the per-port loop detection, mirroring and link control block
//
// Overview of operation
// (R1) With detection on, send probes to set MAC; block a port seeing them back.
// (R2) One probe every two seconds on each port with detection active.
// (R3) Global enable defaults on, per-port enable off; both needed to probe.
// (R4) With recovery option on, unblock after the interval; otherwise stay blocked.
// (R5) Recovery interval is 1 to 60 whole minutes, default one minute.
// (R6) After an automatic unblock, probing resumes on that port.
// (R7) Software reads per-port blocked state and manual recovery completion.
// (R8) Ingress mode copies every frame received on the source to the monitor.
// (R9) Egress mode copies every frame sent on the source to the monitor.
// (R10) Global mirror enable, one source port, one monitor port.
// (R11) The monitor port is never a mirror source.
// (R12) A trunk member port is refused as monitor port.
// (R13) Making the source the monitor drops it from the source set.
// (R14) Full duplex with flow control: pause frame when receive buffers fill.
// (R15) Half duplex with flow control: jam collision at the sending station.
// (R16) Partner without negotiation: speed from line signal, half duplex.
// (R17) Negotiation uses the port's preset speed and duplex.
// (R18) Gigabit copper has no forced mode; negotiation stays on.
// (R19) Crossover swap follows the cable only when speed is auto.
// (R20) Recovery timed by per-port minute counter, restarted on block, cleared on release.
// (R21) Mirroring only adds a copy; normal forwarding is untouched.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module splmc_ctrl #(
	parameter longint PROBE_PERIOD_CYCLES = splmc_pkg::PROBE_PERIOD_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [7:0] rx_hdr_valid,
	input wire logic [7:0] rx_is_probe,
	input wire logic [383:0] rx_dmac,
	output logic [7:0] probe_tx,
	output logic [47:0] probe_dmac,
	output logic [7:0] port_blocked,
	input wire logic [7:0] ing_sof,
	input wire logic [7:0] eg_sof,
	output logic mir_ing_copy,
	output logic mir_eg_copy,
	output logic [2:0] mir_src_port,
	output logic [2:0] mir_dst_port,
	input wire logic [7:0] signal_det,
	input wire logic [15:0] line_speed,
	input wire logic [7:0] partner_an,
	input wire logic [15:0] partner_speed,
	input wire logic [7:0] partner_full,
	input wire logic [7:0] cable_crossed,
	input wire logic [7:0] rx_buf_full,
	input wire logic [7:0] rx_carrier,
	output logic [7:0] link_up,
	output logic [15:0] link_speed,
	output logic [7:0] link_full,
	output logic [7:0] mdix_swap,
	output logic [7:0] pause_tx,
	output logic [7:0] jam_tx
);
	localparam logic [27:0] PER_LAST = 28'(PROBE_PERIOD_CYCLES - 1);
	localparam logic [4:0] MIN_LAST = 5'(splmc_pkg::PERIODS_PER_MIN - 1);

	logic ld_glob_reg;
	logic [31:0] mac_lo_reg;
	logic [15:0] mac_hi_reg;
	logic [7:0] ld_port_en_reg;
	logic [7:0] recov_en_reg;
	logic [5:0] recov_time_reg;
	logic mir_en_reg;
	logic mir_ing_reg;
	logic mir_eg_reg;
	logic [2:0] mir_src_reg;
	logic mir_src_vld_reg;
	logic [2:0] mir_dst_reg;
	logic [7:0] trunk_reg;
	logic [7:0] an_en_reg;
	logic [7:0] fc_en_reg;
	logic [15:0] speed_cfg_reg;
	logic [7:0] full_cfg_reg;
	logic [31:0] rdata_reg;
	logic [27:0] per_cnt_reg;
	logic [4:0] min_cnt_reg;
	logic tick_probe_reg;
	logic tick_min_reg;
	logic ing_copy_reg;
	logic eg_copy_reg;
	logic [7:0] blocked_w;
	logic [7:0] done_w;
	logic [7:0] probe_w;

	// address decode
	wire hit_ld_ctrl = (reg_addr == splmc_pkg::OFS_LD_CTRL);
	wire hit_mac_lo = (reg_addr == splmc_pkg::OFS_LD_MAC_LO);
	wire hit_mac_hi = (reg_addr == splmc_pkg::OFS_LD_MAC_HI);
	wire hit_port_en = (reg_addr == splmc_pkg::OFS_LD_PORT_EN);
	wire hit_recov_en = (reg_addr == splmc_pkg::OFS_LD_RECOV_EN);
	wire hit_recov_time = (reg_addr == splmc_pkg::OFS_LD_RECOV_TIME);
	wire hit_status = (reg_addr == splmc_pkg::OFS_LD_STATUS);
	wire hit_manual = (reg_addr == splmc_pkg::OFS_LD_MANUAL);
	wire hit_mir = (reg_addr == splmc_pkg::OFS_MIR_CTRL);
	wire hit_trunk = (reg_addr == splmc_pkg::OFS_TRUNK);
	wire hit_an = (reg_addr == splmc_pkg::OFS_AN_EN);
	wire hit_fc = (reg_addr == splmc_pkg::OFS_FC_EN);
	wire hit_speed = (reg_addr == splmc_pkg::OFS_SPEED);
	wire hit_full = (reg_addr == splmc_pkg::OFS_FULL);
	wire hit_lstat = (reg_addr == splmc_pkg::OFS_LINK_STATUS);
	wire hit_lspeed = (reg_addr == splmc_pkg::OFS_LINK_SPEED);

	// out-of-range recovery times are ignored so the interval stays legal
	wire [5:0] wr_time = reg_wdata[5:0];
	wire time_ok = (wr_time >= splmc_pkg::RECOV_MIN) && (wr_time <= splmc_pkg::RECOV_MAX); // [R5]

	// mirror write: trunk monitor refused, source equal to monitor dropped
	wire [2:0] wr_dst = reg_wdata[splmc_pkg::MIR_DST_LSB +: 3];
	wire [2:0] wr_src = reg_wdata[splmc_pkg::MIR_SRC_LSB +: 3];
	wire [2:0] new_dst = trunk_reg[wr_dst] ? mir_dst_reg : wr_dst; // [R12]
	wire new_src_vld = reg_wdata[splmc_pkg::MIR_SRC_VLD_BIT] & (wr_src != new_dst); // [R11] [R13]

	// readback values
	wire [7:0] link_up_w;
	wire [15:0] link_speed_w;
	wire [7:0] link_full_w;
	wire [7:0] swap_w;
	wire [7:0] pause_w;
	wire [7:0] jam_w;
	wire [31:0] mir_rd = {21'h000000, mir_dst_reg, mir_src_vld_reg, mir_src_reg, 1'b0, mir_eg_reg, mir_ing_reg,
		mir_en_reg};
	wire [31:0] rd_mux =
		hit_ld_ctrl ? {31'h00000000, ld_glob_reg} :
		hit_mac_lo ? mac_lo_reg :
		hit_mac_hi ? {16'h0000, mac_hi_reg} :
		hit_port_en ? {24'h000000, ld_port_en_reg} :
		hit_recov_en ? {24'h000000, recov_en_reg} :
		hit_recov_time ? {26'h0000000, recov_time_reg} :
		hit_status ? {16'h0000, done_w, blocked_w} : // [R7]
		hit_mir ? mir_rd :
		hit_trunk ? {24'h000000, trunk_reg} :
		hit_an ? {24'h000000, an_en_reg} :
		hit_fc ? {24'h000000, fc_en_reg} :
		hit_speed ? {16'h0000, speed_cfg_reg} :
		hit_full ? {24'h000000, full_cfg_reg} :
		hit_lstat ? {8'h00, swap_w, link_full_w, link_up_w} :
		hit_lspeed ? {16'h0000, link_speed_w} :
		32'h00000000;

	// loop detection configuration
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ld_glob_reg <= splmc_pkg::RST_LD_GLOBAL; // [R3]
			mac_lo_reg <= 32'h00000000;
			mac_hi_reg <= 16'h0000;
			ld_port_en_reg <= splmc_pkg::RST_LD_PORT_EN; // [R3]
			recov_en_reg <= splmc_pkg::RST_RECOV_EN; // [R4]
			recov_time_reg <= splmc_pkg::RST_RECOV_TIME; // [R5]
		end else if (reg_wr) begin
			if (hit_ld_ctrl) ld_glob_reg <= reg_wdata[0];
			if (hit_mac_lo) mac_lo_reg <= reg_wdata;
			if (hit_mac_hi) mac_hi_reg <= reg_wdata[15:0];
			if (hit_port_en) ld_port_en_reg <= reg_wdata[7:0];
			if (hit_recov_en) recov_en_reg <= reg_wdata[7:0];
			if (hit_recov_time && time_ok) recov_time_reg <= wr_time; // [R5]
		end
	end

	// mirror and trunk configuration
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mir_en_reg <= 1'b0;
			mir_ing_reg <= 1'b0;
			mir_eg_reg <= 1'b0;
			mir_src_reg <= 3'h0;
			mir_src_vld_reg <= 1'b0;
			mir_dst_reg <= 3'h0;
			trunk_reg <= 8'h00;
		end else if (reg_wr) begin
			if (hit_mir) begin
				mir_en_reg <= reg_wdata[splmc_pkg::MIR_EN_BIT]; // [R10]
				mir_ing_reg <= reg_wdata[splmc_pkg::MIR_ING_BIT];
				mir_eg_reg <= reg_wdata[splmc_pkg::MIR_EG_BIT];
				mir_src_reg <= wr_src;
				mir_src_vld_reg <= new_src_vld; // [R13]
				mir_dst_reg <= new_dst; // [R12]
			end
			if (hit_trunk) trunk_reg <= reg_wdata[7:0];
		end
	end

	// link configuration
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			an_en_reg <= splmc_pkg::RST_AN_EN;
			fc_en_reg <= splmc_pkg::RST_FC_EN;
			speed_cfg_reg <= splmc_pkg::RST_SPEED;
			full_cfg_reg <= splmc_pkg::RST_FULL;
		end else if (reg_wr) begin
			if (hit_an) an_en_reg <= reg_wdata[7:0];
			if (hit_fc) fc_en_reg <= reg_wdata[7:0];
			if (hit_speed) speed_cfg_reg <= reg_wdata[15:0];
			if (hit_full) full_cfg_reg <= reg_wdata[7:0];
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 32'h00000000;
		end else begin
			rdata_reg <= reg_rd ? rd_mux : 32'h00000000;
		end
	end

	// two-second and one-minute ticks shared by all ports
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			per_cnt_reg <= 28'h0000000;
			min_cnt_reg <= 5'h00;
			tick_probe_reg <= 1'b0;
			tick_min_reg <= 1'b0;
		end else begin
			tick_probe_reg <= (per_cnt_reg == PER_LAST); // [R2]
			tick_min_reg <= (per_cnt_reg == PER_LAST) && (min_cnt_reg == MIN_LAST); // [R20]
			per_cnt_reg <= (per_cnt_reg == PER_LAST) ? 28'h0000000 : per_cnt_reg + 28'h0000001;
			if (per_cnt_reg == PER_LAST) begin
				min_cnt_reg <= (min_cnt_reg == MIN_LAST) ? 5'h00 : min_cnt_reg + 5'h01;
			end
		end
	end

	// per-port loop and link logic
	genvar gp;
	generate
		for (gp = 0; gp < splmc_pkg::NPORT; gp++) begin : g_port
			// a looped probe carries our type and our destination address
			wire probe_back = rx_hdr_valid[gp] & rx_is_probe[gp] & (rx_dmac[gp*48 +: 48] == {mac_hi_reg, mac_lo_reg}); // [R1]
			// gigabit preset forces negotiation on, there is no forced gigabit mode
			wire an_eff = an_en_reg[gp] | (speed_cfg_reg[gp*2 +: 2] == splmc_pkg::SPD_1000); // [R18]
			splmc_loop_port u_loop (
				.clk(clk),
				.rst_n(rst_n),
				.tick_probe(tick_probe_reg),
				.tick_min(tick_min_reg),
				.probe_active(ld_glob_reg & ld_port_en_reg[gp]), // [R3]
				.recov_en(recov_en_reg[gp]),
				.recov_time(recov_time_reg),
				.probe_rx(probe_back),
				.manual_clr(reg_wr & hit_manual & reg_wdata[gp]),
				.blocked(blocked_w[gp]),
				.manual_done(done_w[gp]),
				.probe_tx(probe_w[gp])
			);
			splmc_link_port u_link (
				.clk(clk),
				.rst_n(rst_n),
				.an_en(an_eff),
				.cfg_speed(speed_cfg_reg[gp*2 +: 2]),
				.cfg_full(full_cfg_reg[gp]),
				.fc_en(fc_en_reg[gp]),
				.signal_det(signal_det[gp]),
				.line_speed(line_speed[gp*2 +: 2]),
				.partner_an(partner_an[gp]),
				.partner_speed(partner_speed[gp*2 +: 2]),
				.partner_full(partner_full[gp]),
				.cable_crossed(cable_crossed[gp]),
				.rx_buf_full(rx_buf_full[gp]),
				.rx_carrier(rx_carrier[gp]),
				.link_up(link_up_w[gp]),
				.speed(link_speed_w[gp*2 +: 2]),
				.full(link_full_w[gp]),
				.mdix_swap(swap_w[gp]),
				.pause_tx(pause_w[gp]),
				.jam_tx(jam_w[gp])
			);
		end
	endgenerate

	// mirror copy requests; forwarding of the original never passes through here
	wire mir_live = mir_en_reg & mir_src_vld_reg & (mir_src_reg != mir_dst_reg); // [R10] [R11] [R21]
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ing_copy_reg <= 1'b0;
			eg_copy_reg <= 1'b0;
		end else begin
			ing_copy_reg <= mir_live & mir_ing_reg & ing_sof[mir_src_reg]; // [R8]
			eg_copy_reg <= mir_live & mir_eg_reg & eg_sof[mir_src_reg]; // [R9]
		end
	end

	// outputs straight from flops
	assign reg_rdata = rdata_reg;
	assign probe_tx = probe_w;
	assign probe_dmac = {mac_hi_reg, mac_lo_reg};
	assign port_blocked = blocked_w;
	assign mir_ing_copy = ing_copy_reg;
	assign mir_eg_copy = eg_copy_reg;
	assign mir_src_port = mir_src_reg;
	assign mir_dst_port = mir_dst_reg;
	assign link_up = link_up_w;
	assign link_speed = link_speed_w;
	assign link_full = link_full_w;
	assign mdix_swap = swap_w;
	assign pause_tx = pause_w;
	assign jam_tx = jam_w;

	// rule checks sit beside the logic; link checks watch port 0 as a sample of all ports
	ing_copy_a: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
		(mir_live && mir_ing_reg && ing_sof[mir_src_reg]) |=> ing_copy_reg) else $error("ingress copy missing");
	eg_copy_a: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
		(mir_live && mir_eg_reg && eg_sof[mir_src_reg]) |=> eg_copy_reg) else $error("egress copy missing");
	mirror_off_a: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
		!$past(mir_en_reg) |-> !(ing_copy_reg || eg_copy_reg)) else $error("copy while mirror off");
	monitor_not_src_a: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
		mir_src_vld_reg |-> (mir_src_reg != mir_dst_reg)) else $error("monitor is also source");
	trunk_dst_kept_a: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
		(reg_wr && hit_mir && trunk_reg[wr_dst]) |=> $stable(mir_dst_reg)) else $error("trunk monitor taken");
	src_drop_a: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
		(reg_wr && hit_mir && (wr_src == new_dst)) |=> !mir_src_vld_reg) else $error("source kept as monitor");
	probe_needs_en_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
		(probe_w != 8'h00) |-> $past(ld_glob_reg)) else $error("probe with global off");
	probe_on_tick_a: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
		(probe_w != 8'h00) |-> $past(tick_probe_reg)) else $error("probe outside its period");
	time_range_a: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
		(recov_time_reg >= 6'h01) && (recov_time_reg <= 6'h3C)) else $error("recovery time out of range");
	status_read_a: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
		(reg_rd && hit_status) |=> (reg_rdata[7:0] == $past(blocked_w))) else $error("bad status read");
	half_no_nego_a: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
		!partner_an[0] |=> !link_full_w[0]) else $error("full duplex without negotiation");
	jam_half_only_a: assert property (@(posedge clk) disable iff (!rst_n) // [R15]
		jam_w[0] |-> !$past(link_full_w[0])) else $error("jam in full duplex");
	gig_forced_an_a: assert property (@(posedge clk) disable iff (!rst_n) // [R18]
		(speed_cfg_reg[1:0] == 2'h2 && partner_an[0]) |=> (link_speed_w[1:0] == 2'h2)) else $error("gig forced mode");

	block_cov: cover property (@(posedge clk) disable iff (!rst_n) $rose(blocked_w[0]));
	recover_cov: cover property (@(posedge clk) disable iff (!rst_n) $fell(blocked_w[0]));
	mirror_cov: cover property (@(posedge clk) disable iff (!rst_n) ing_copy_reg && eg_copy_reg);
	pause_cov: cover property (@(posedge clk) disable iff (!rst_n) pause_w != 8'h00);
	jam_cov: cover property (@(posedge clk) disable iff (!rst_n) jam_w != 8'h00);
endmodule
`default_nettype wire

/* File: sim/splmc_partner.sv */
// link partner station model shared by every switch port
`timescale 1ns/1ns
`default_nettype none
module splmc_partner (
	input wire logic an,
	input wire logic [1:0] spd,
	input wire logic full_in,
	input wire logic tx,
	output logic [7:0] signal_det,
	output logic [15:0] line_speed,
	output logic [7:0] partner_an,
	output logic [15:0] partner_speed,
	output logic [7:0] partner_full,
	output logic [7:0] rx_carrier
);
	// one station type on all ports keeps the model small
	assign signal_det = 8'hFF;
	assign line_speed = {8{spd}};
	assign partner_an = {8{an}};
	assign partner_speed = {8{spd}};
	assign partner_full = {8{full_in}};
	assign rx_carrier = {8{tx}};
endmodule
`default_nettype wire

/* File: sim/splmc_ctrl_bench.sv */
// self-checking bench for the loop, mirror and link control block
`timescale 1ns/1ns
`default_nettype none
module splmc_ctrl_bench;
	logic clk, rst_n, reg_wr, reg_rd, p_an, p_full, p_tx, mir_ing_copy, mir_eg_copy;
	logic [7:0] reg_addr, rx_hdr_valid, rx_is_probe, ing_sof, eg_sof, cable_crossed, rx_buf_full;
	logic [7:0] probe_tx, port_blocked, link_up, link_full, mdix_swap, pause_tx, jam_tx;
	logic [7:0] signal_det, partner_an, partner_full, rx_carrier;
	logic [31:0] reg_wdata, reg_rdata, seed;
	logic [383:0] rx_dmac;
	logic [47:0] probe_dmac, mac;
	logic [2:0] mir_src_port, mir_dst_port;
	logic [15:0] link_speed, line_speed, partner_speed;
	logic [1:0] p_spd;
	int n_errors, check_count, cyc, i, c0, c1, m_dst, m_vld;
	splmc_ctrl #(.PROBE_PERIOD_CYCLES(20)) u_splmc_ctrl (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .rx_hdr_valid, .rx_is_probe, .rx_dmac, .probe_tx, .probe_dmac, .port_blocked,
		.ing_sof, .eg_sof, .mir_ing_copy, .mir_eg_copy, .mir_src_port, .mir_dst_port, .signal_det,
		.line_speed, .partner_an, .partner_speed, .partner_full, .cable_crossed, .rx_buf_full,
		.rx_carrier, .link_up, .link_speed, .link_full, .mdix_swap, .pause_tx, .jam_tx);
	splmc_partner u_splmc_partner (.an(p_an), .spd(p_spd), .full_in(p_full), .tx(p_tx), .signal_det,
		.line_speed, .partner_an, .partner_speed, .partner_full, .rx_carrier);
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	task automatic report_and_stop;
		if (n_errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
		@(posedge clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 chk(reg_rdata, e, w);
	endtask
	// probes seen in n cycles on port 0 and on the other ports
	task automatic cnt(input int n);
		c0 = 0;
		c1 = 0;
		repeat (n) begin
			@(posedge clk);
			#1 c0 += probe_tx[0];
			c1 += $countones(probe_tx[7:1]);
		end
	endtask
	task automatic rxp;
		@(posedge clk);
		rx_hdr_valid <= 8'h01;
		@(posedge clk);
		rx_hdr_valid <= 8'h00;
		#1 chk(port_blocked, 8'h01, "blk");
	endtask
	// mirror model: trunk port 3 is refused as monitor, source equal to monitor is dropped
	task automatic mir(input int en, input int md, input int s, input int d);
		wr(8'h20, {21'h0, d[2:0], 1'h1, s[2:0], 1'h0, md[1:0], en[0]});
		if (d != 3) m_dst = d;
		m_vld = (s != m_dst);
		for (i = 0; i < 8; i++) begin
			@(posedge clk);
			ing_sof[i] <= 1'h1;
			eg_sof[i] <= 1'h1;
			@(posedge clk);
			ing_sof <= 8'h00;
			eg_sof <= 8'h00;
			#1 chk(mir_ing_copy, en && md[0] && m_vld && i == s, "ing");
			chk(mir_eg_copy, en && md[1] && m_vld && i == s, "eg");
		end
		chk(mir_dst_port, m_dst[2:0], "dst");
		chk(mir_src_port, s[2:0], "src");
	endtask
	initial begin
		seed = 32'hC37EA032;
		{rst_n, reg_wr, reg_rd, p_an, p_full, p_tx} = 6'h03;
		{reg_addr, rx_hdr_valid, ing_sof, eg_sof, rx_buf_full} = 40'h0;
		{rx_is_probe, cable_crossed, p_spd, reg_wdata} = {16'hFFFF, 2'h1, 32'h0};
		mac = 48'({$random(seed), $random(seed)});
		rx_dmac = {8{mac}};
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		rd(8'h00, 32'h1, "glob");
		rd(8'h0C, 32'h0, "pen");
		rd(8'h10, 32'hFF, "ren");
		rd(8'h14, 32'h1, "rtime");
		wr(8'h40, $random(seed));
		rd(8'h40, 32'h0, "unmap");
		wr(8'h04, mac[31:0]);
		wr(8'h08, {16'h0, mac[47:32]});
		wr(8'h0C, 32'h1);
		cnt(100);
		chk(c0, 5, "probes");
		chk(c1, 0, "idle");
		chk(probe_dmac, mac, "pmac");
		rxp();
		rd(8'h18, 32'h1, "stat");
		cnt(40);
		chk(c0, 0, "mute");
		for (i = 0; i < 700 && port_blocked[0]; i++) @(negedge clk);
		chk(i < 620, 1'h1, "recov");
		cnt(40);
		chk(c0, 2, "resume");
		wr(8'h10, 32'hFE);
		rxp();
		cnt(1300);
		chk(port_blocked, 8'h01, "stay");
		wr(8'h1C, 32'h1);
		rd(8'h18, 32'h100, "manual");
		wr(8'h14, 32'h0);
		wr(8'h14, 32'h3D);
		rd(8'h14, 32'h1, "range");
		wr(8'h14, 32'h3C);
		rd(8'h14, 32'h3C, "max");
		wr(8'h24, 32'h8);
		mir(1, 1, 2, 5);
		mir(1, 2, 2, 3);
		mir(0, 3, 2, 5);
		mir(1, 3, 5, 5);
		wr(8'h2C, 32'hFF);
		p_an <= 1'h1;
		repeat (3) @(posedge clk);
		#1 chk(link_up, 8'hFF, "up");
		chk({link_speed[1:0], link_full[0], mdix_swap}, {2'h1, 1'h1, 8'hFF}, "neg");
		@(posedge clk);
		rx_buf_full <= 8'hFF;
		@(posedge clk);
		#1 chk({pause_tx, jam_tx}, 16'hFF00, "pause");
		@(posedge clk);
		#1 chk(pause_tx, 8'h00, "pulse");
		@(posedge clk);
		p_an <= 1'h0;
		p_spd <= 2'h2;
		p_tx <= 1'h1;
		repeat (3) @(posedge clk);
		#1 chk({link_speed[1:0], link_full, jam_tx}, {2'h2, 16'h00FF}, "half");
		wr(8'h28, 32'h0);
		wr(8'h30, 32'hFFFE);
		p_an <= 1'h1;
		p_spd <= 2'h1;
		repeat (3) @(posedge clk);
		#1 chk({link_speed[3:0], link_full[1:0], mdix_swap}, {4'h6, 2'h1, 8'hFE}, "gig");
		rd(8'h38, 32'h00FE01FF, "lstat");
		rd(8'h3C, 32'h5556, "lspeed");
		report_and_stop();
	end
endmodule
`default_nettype wire
